// *** cpmd_top.sv ***
// Charging port mode decoder: mode decode, discharge sequencing, status timing
`timescale 1ns/10ps
module cpmd_top
	import cpmd_pkg::*;
#(
	parameter int STAT_ON_CYC = cpmd_pkg::CPMD_STAT_ON_CYC,
	parameter int STAT_OFF_CYC = cpmd_pkg::CPMD_STAT_OFF_CYC
) (
	input wire logic clk_i, // 100 MHz clock
	input wire logic srst_i, // Sync reset, active high
	input wire logic mode_select_a_i, // Mode pin, code bit 2
	input wire logic mode_select_b_i, // Mode pin, code bit 1
	input wire logic mode_select_c_i, // Mode pin, code bit 0
	input wire logic enable_i, // Device enable pin
	input wire logic overcurrent_i, // Comparator: load above limit
	input wire logic load_above_lo_i, // Comparator: load above low+40 mA
	input wire logic load_below_lo_i, // Comparator: load below low-10 mA
	input wire logic [3:0] reg_addr_i, // Register address
	input wire logic [7:0] reg_wdata_i, // Write data
	input wire logic reg_wr_i, // Write strobe
	input wire logic reg_rd_i, // Read strobe
	output logic [7:0] reg_rdata_o, // Read data, cycle after strobe
	output logic irq_o, // Level interrupt
	output logic power_switch_on_o, // Power switch on
	output logic limit_high_o, // 1 high limit, 0 low limit
	output logic limit_active_o, // Current limit applied
	output logic data_switch_on_o, // Data-line switches on
	output logic discharge_o, // Output discharge running
	output logic dcp_auto_en_o, // DCP auto detection enabled
	output logic cdp_auto_sw_en_o, // CDP-SDP auto switch enabled
	output logic status_n_o, // Status, active low
	output logic fault_n_o, // Fault, active low
	output logic cable_sense_en_o // Cable-sense output enabled
);
	import cpmd_pkg::*;

	logic [5:0] pins_s;
	logic [2:0] code_s;
	logic en_s, oc_s, above_s, below_s;

	// Mode, enable and comparator pins are asynchronous, so all pass two flops
	cpmd_sync #(.W(6)) u_sync (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.d_i({mode_select_a_i, mode_select_b_i, mode_select_c_i, enable_i,
			overcurrent_i, load_above_lo_i}),
		.q_o(pins_s)
	);
	logic [0:0] below_sync;
	cpmd_sync #(.W(1)) u_sync_b (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.d_i(load_below_lo_i),
		.q_o(below_sync)
	);
	assign code_s = pins_s[5:3];
	assign en_s = pins_s[2];
	assign oc_s = pins_s[1];
	assign above_s = pins_s[0];
	assign below_s = below_sync[0];

	// Decode of the synchronised code, recomputed every cycle
	cpmd_mode_t dec_mode;
	always_comb begin
		unique casez (code_s)
			3'b000: dec_mode = CPMD_M_DCP_LO;
			3'b001: dec_mode = CPMD_M_DCP;
			3'b01?: dec_mode = CPMD_M_SDP;
			3'b10?: dec_mode = CPMD_M_CLIENT;
			3'b110: dec_mode = CPMD_M_STANDARD_PORT_LOW_LIMIT_MODE_LO;
			default: dec_mode = CPMD_M_CDP;
		endcase
	end

	// Mode tracking and discharge sequencing
	cpmd_mode_t mode_q, mode_d;
	logic [2:0] code_q, code_d;
	logic [CPMD_CNT_W-1:0] dis_cnt_q, dis_cnt_d;
	logic dis_q, dis_d;
	logic chg_ev, dis_done_ev;
	logic exempt;
	always_comb begin
		mode_d = mode_q;
		code_d = code_q;
		dis_cnt_d = dis_cnt_q;
		dis_d = dis_q;
		chg_ev = 1'b0;
		dis_done_ev = 1'b0;
		// Pairs that swap with the output kept up
		exempt = ((code_q == CPMD_CODE_DCP_LO) && (code_s == CPMD_CODE_DCP)) ||
			((code_q == CPMD_CODE_DCP) && (code_s == CPMD_CODE_DCP_LO)) ||
			((code_q == CPMD_CODE_STANDARD_PORT_LOW_LIMIT_MODE_LO) && (code_s == CPMD_CODE_CDP)) ||
			((code_q == CPMD_CODE_CDP) && (code_s == CPMD_CODE_STANDARD_PORT_LOW_LIMIT_MODE_LO));
		if (code_s != code_q) begin
			code_d = code_s;
			chg_ev = 1'b1;
			if (exempt) begin
				mode_d = dec_mode;
			end else begin
				// New code restarts any running discharge
				dis_d = 1'b1;
				dis_cnt_d = '0;
			end
		end else if (dis_q) begin
			if (dis_cnt_q >= CPMD_CNT_W'(CPMD_DISCH_CYC - 1)) begin
				dis_d = 1'b0;
				mode_d = dec_mode;
				dis_done_ev = 1'b1;
			end else begin
				dis_cnt_d = dis_cnt_q + 1'b1;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			mode_q <= CPMD_M_DCP_LO;
			code_q <= CPMD_CODE_DCP_LO;
			dis_cnt_q <= '0;
			dis_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			code_q <= code_d;
			dis_cnt_q <= dis_cnt_d;
			dis_q <= dis_d;
		end
	end

	// Mode attributes; client mode leaves every indication inactive
	logic stat_en, lim_hi, cs_en, client, lo_mode;
	assign client = (mode_q == CPMD_M_CLIENT);
	assign lim_hi = (mode_q == CPMD_M_DCP) || (mode_q == CPMD_M_CDP);
	assign stat_en = lim_hi;
	assign cs_en = !client;
	assign lo_mode = (mode_q == CPMD_M_DCP_LO) || (mode_q == CPMD_M_STANDARD_PORT_LOW_LIMIT_MODE_LO);

	// Status qualification timers
	logic [CPMD_CNT_W-1:0] st_cnt_q, st_cnt_d;
	logic st_q, st_d, st_ev;
	always_comb begin
		st_cnt_d = st_cnt_q;
		st_d = st_q;
		st_ev = 1'b0;
		if (!stat_en) begin
			st_d = 1'b0;
			st_cnt_d = '0;
		end else if (!st_q) begin
			// Qualify high load for the full on time
			if (!above_s) begin
				st_cnt_d = '0;
			end else if (st_cnt_q >= CPMD_CNT_W'(STAT_ON_CYC - 1)) begin
				st_d = 1'b1;
				st_cnt_d = '0;
				st_ev = 1'b1;
			end else begin
				st_cnt_d = st_cnt_q + 1'b1;
			end
		end else begin
			// Longer release time keeps port allocation stable
			if (!below_s) begin
				st_cnt_d = '0;
			end else if (st_cnt_q >= CPMD_CNT_W'(STAT_OFF_CYC - 1)) begin
				st_d = 1'b0;
				st_cnt_d = '0;
				st_ev = 1'b1;
			end else begin
				st_cnt_d = st_cnt_q + 1'b1;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_cnt_q <= '0;
			st_q <= 1'b0;
		end else begin
			st_cnt_q <= st_cnt_d;
			st_q <= st_d;
		end
	end

	// Register file and interrupt logic
	logic [CPMD_IRQ_W-1:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d, irq_set;
	logic [7:0] ctrl_q, ctrl_d, rdata_d;
	logic oc_flag;
	assign oc_flag = oc_s && !client && !lo_mode;
	always_comb begin
		irq_set = '0;
		irq_set[CPMD_IRQ_MODE] = chg_ev;
		irq_set[CPMD_IRQ_DISCH] = dis_done_ev;
		irq_set[CPMD_IRQ_STAT] = st_ev;
		irq_set[CPMD_IRQ_OC] = oc_flag;
		irq_st_d = irq_st_q;
		irq_mask_d = irq_mask_q;
		ctrl_d = ctrl_q;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				CPMD_REG_IRQ_STATUS: irq_st_d = irq_st_q & ~reg_wdata_i[CPMD_IRQ_W-1:0];
				CPMD_REG_IRQ_MASK: irq_mask_d = reg_wdata_i[CPMD_IRQ_W-1:0];
				CPMD_REG_CTRL: ctrl_d = reg_wdata_i;
				default: ;
			endcase
		end
		// Set after clear so an event in the clear cycle survives
		irq_st_d = irq_st_d | irq_set;
		rdata_d = 8'h00;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				CPMD_REG_MODE: rdata_d = {dis_q, st_q, code_q, mode_q};
				CPMD_REG_IRQ_STATUS: rdata_d = {4'h0, irq_st_q};
				CPMD_REG_IRQ_MASK: rdata_d = {4'h0, irq_mask_q};
				CPMD_REG_CTRL: rdata_d = ctrl_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			irq_st_q <= '0;
			irq_mask_q <= CPMD_MASK_RST;
			ctrl_q <= CPMD_CTRL_RST;
			reg_rdata_o <= 8'h00;
			irq_o <= 1'b0;
		end else begin
			irq_st_q <= irq_st_d;
			irq_mask_q <= irq_mask_d;
			ctrl_q <= ctrl_d;
			reg_rdata_o <= rdata_d;
			irq_o <= |(irq_st_d & irq_mask_d);
		end
	end

	// Registered pin outputs; ctrl bit 0 forces the port off by software
	logic run;
	assign run = en_s && !ctrl_q[0];
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			power_switch_on_o <= 1'b0;
			limit_high_o <= 1'b0;
			limit_active_o <= 1'b0;
			data_switch_on_o <= 1'b0;
			discharge_o <= 1'b0;
			dcp_auto_en_o <= 1'b0;
			cdp_auto_sw_en_o <= 1'b0;
			status_n_o <= 1'b1;
			fault_n_o <= 1'b1;
			cable_sense_en_o <= 1'b0;
		end else begin
			power_switch_on_o <= run && !dis_d && !client;
			limit_high_o <= lim_hi;
			limit_active_o <= !client;
			data_switch_on_o <= run && !dis_d && (client || !(mode_q == CPMD_M_DCP_LO ||
				mode_q == CPMD_M_DCP));
			discharge_o <= dis_d;
			dcp_auto_en_o <= run && (mode_q == CPMD_M_DCP_LO || mode_q == CPMD_M_DCP);
			cdp_auto_sw_en_o <= run && (mode_q == CPMD_M_CDP);
			status_n_o <= !(stat_en && st_q);
			fault_n_o <= !oc_flag;
			cable_sense_en_o <= cs_en;
		end
	end
endmodule

// *** cpmd_pkg.sv ***
// Package of constants and types for the charging port mode decoder
package cpmd_pkg;
	// Mode-select codes, bit 2 is mode_select_a, bit 0 is mode_select_c
	localparam logic [2:0] CPMD_CODE_DCP_LO = 3'h0;
	localparam logic [2:0] CPMD_CODE_DCP = 3'h1;
	localparam logic [2:0] CPMD_CODE_STANDARD_PORT_LOW_LIMIT_MODE_LO = 3'h6;
	localparam logic [2:0] CPMD_CODE_CDP = 3'h7;
	// Clock rate and timing figures
	localparam int CPMD_CLK_HZ = 100_000_000;
	localparam int CPMD_STAT_ON_MS = 210;
	localparam int CPMD_STAT_OFF_S = 3;
	localparam int CPMD_DISCH_US = 10;
	localparam int CPMD_STAT_ON_CYC = CPMD_STAT_ON_MS * (CPMD_CLK_HZ / 1000);
	localparam int CPMD_STAT_OFF_CYC = CPMD_STAT_OFF_S * CPMD_CLK_HZ;
	localparam int CPMD_DISCH_CYC = CPMD_DISCH_US * (CPMD_CLK_HZ / 1_000_000);
	localparam int CPMD_CNT_W = 32;
	// Interrupt status bits
	localparam int CPMD_IRQ_W = 4;
	localparam int CPMD_IRQ_MODE = 0;
	localparam int CPMD_IRQ_DISCH = 1;
	localparam int CPMD_IRQ_STAT = 2;
	localparam int CPMD_IRQ_OC = 3;
	// Register offsets
	localparam logic [3:0] CPMD_REG_MODE = 4'h0;
	localparam logic [3:0] CPMD_REG_IRQ_STATUS = 4'h1;
	localparam logic [3:0] CPMD_REG_IRQ_MASK = 4'h2;
	localparam logic [3:0] CPMD_REG_CTRL = 4'h3;
	localparam logic [7:0] CPMD_CTRL_RST = 8'h00;
	localparam logic [3:0] CPMD_MASK_RST = 4'h0;
	// Decoded operating modes
	typedef enum logic [2:0] {
		CPMD_M_DCP_LO, CPMD_M_DCP, CPMD_M_SDP, CPMD_M_CLIENT, CPMD_M_STANDARD_PORT_LOW_LIMIT_MODE_LO, CPMD_M_CDP
	} cpmd_mode_t;
endpackage

// *** cpmd_sync.sv ***
// Two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/10ps
module cpmd_sync #(
	parameter int W = 1
) (
	input wire logic clk_i, // Clock
	input wire logic srst_i, // Sync reset
	input wire logic [W-1:0] d_i, // Async levels
	output logic [W-1:0] q_o // Synchronised levels
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	// First stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
		end
	end
	assign q_o = s2_q;
endmodule

// *** cpmd_host_model.sv ***
// Host controller model driving the three mode-select pins
`timescale 1ns/10ps
module cpmd_host_model (
	input wire logic clk_i, // Clock
	input wire logic [2:0] code_i, // Requested code
	output logic mode_select_a_o = 1'b0, // Code bit 2
	output logic mode_select_b_o = 1'b0, // Code bit 1
	output logic mode_select_c_o = 1'b0 // Code bit 0
);
	// Pins move just after an edge, always to a legal code
	always @(posedge clk_i) begin
		{mode_select_a_o, mode_select_b_o, mode_select_c_o} <= code_i;
	end
endmodule

// *** cpmd_top_properties.sv ***
// Checker of port relations of the charging port mode decoder
`timescale 1ns/10ps
module cpmd_top_properties (
	input wire logic clk_i, // Clock
	input wire logic srst_i, // Sync reset
	input wire logic power_switch_on_o, // Switch on
	input wire logic limit_high_o, // High limit
	input wire logic limit_active_o, // Limit applied
	input wire logic data_switch_on_o, // Data on
	input wire logic discharge_o, // Discharge
	input wire logic dcp_auto_en_o, // DCP auto
	input wire logic cdp_auto_sw_en_o, // CDP auto switch
	input wire logic status_n_o, // Status, active low
	input wire logic fault_n_o, // Fault, active low
	input wire logic cable_sense_en_o // Cable sense
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// Discharge steps: start, then both switches held open
	sequence s_go; $rose(discharge_o); endsequence
	sequence s_off; !power_switch_on_o && !data_switch_on_o; endsequence
	property p_dis_go; s_go |-> s_off ##1 s_off [*2]; endproperty
	property p_dis_run; discharge_o |-> s_off; endproperty
	property p_client; !limit_active_o |-> !power_switch_on_o && status_n_o && fault_n_o; endproperty
	property p_cable; cable_sense_en_o == limit_active_o; endproperty
	property p_cdp; cdp_auto_sw_en_o |-> limit_high_o && cable_sense_en_o; endproperty
	property p_dcp; dcp_auto_en_o |-> !data_switch_on_o && limit_active_o; endproperty
	property p_lim; limit_high_o |-> limit_active_o; endproperty
	// Edge forms; status, fault and the mode outputs all register from the same mode_q, so there is no skew
	property p_stat; $fell(status_n_o) |-> limit_high_o; endproperty
	property p_fault; $fell(fault_n_o) |-> !(dcp_auto_en_o && !limit_high_o); endproperty
	a_dis_go: assert property (p_dis_go) else $error("switch on at discharge start");
	a_dis_run: assert property (p_dis_run) else $error("switch on in discharge");
	a_client: assert property (p_client) else $error("client outputs active");
	a_cable: assert property (p_cable) else $error("cable sense wrong");
	a_cdp: assert property (p_cdp) else $error("auto switch outside high limit");
	a_dcp: assert property (p_dcp) else $error("data on in dedicated charging");
	a_lim: assert property (p_lim) else $error("high limit without limit");
	a_stat: assert property (p_stat) else $error("status in low limit mode");
	a_fault: assert property (p_fault) else $error("fault in low dedicated mode");
endmodule
bind cpmd_top cpmd_top_properties u_props (.*);

// *** tb_cpmd_top.sv ***
// Testbench of the charging port mode decoder
`timescale 1ns/10ps
module tb_cpmd_top;
	import cpmd_pkg::*;
	logic clk_i = 0, srst_i = 1, en = 1, oc = 0, above = 0, below = 0, wr = 0, rd = 0;
	logic [2:0] code = 3'h0, prev = 3'h0, cur;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata, rv, outs;
	logic irq, pwr, lhi, lact, dsw, dis, dauto, cauto, stn, ftn, cse, ma, mb, mc;
	int mismatches = 0, checks_done = 0, n;
	logic [2:0] seq [11] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h6, 3'h1};
	logic [2:0] mode_of [8] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5};
	assign outs = {lhi, lact, pwr, dsw, dauto, cauto, cse, 1'b0};
	cpmd_host_model host (.clk_i(clk_i), .code_i(code), .mode_select_a_o(ma),
		.mode_select_b_o(mb), .mode_select_c_o(mc));
	// Short status counts keep the run brief
	cpmd_top #(.STAT_ON_CYC(20), .STAT_OFF_CYC(30)) dut (.clk_i(clk_i), .srst_i(srst_i),
		.mode_select_a_i(ma), .mode_select_b_i(mb), .mode_select_c_i(mc), .enable_i(en),
		.overcurrent_i(oc), .load_above_lo_i(above), .load_below_lo_i(below),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .irq_o(irq), .power_switch_on_o(pwr), .limit_high_o(lhi),
		.limit_active_o(lact), .data_switch_on_o(dsw), .discharge_o(dis),
		.dcp_auto_en_o(dauto), .cdp_auto_sw_en_o(cauto), .status_n_o(stn),
		.fault_n_o(ftn), .cable_sense_en_o(cse));
	// Clock, 10 ns period
	always #5 clk_i = ~clk_i;
	task automatic check(input string name, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, e, s);
		end
	endtask
	// Sample just past the edge so its updates have landed
	task automatic wait_n(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic report_and_stop();
		if (mismatches == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Walk the code table, exempt and discharging changes both ways
	initial begin
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		for (int i = 0; i < 11; i++) begin
			cur = seq[i];
			@(posedge clk_i);
			code <= cur;
			n = 0;
			repeat (1100) begin
				wait_n(1);
				n += int'(dis);
			end
			if ((prev < 3'h2 && cur < 3'h2) || (prev > 3'h5 && cur > 3'h5)) begin
				check("discharge", 16'(n), 16'h0000);
			end else begin
				check("discharge", 16'(n), 16'(CPMD_DISCH_CYC));
			end
			check("outs", 16'(outs), 16'({cur == 3'h1 || cur == 3'h7, !(cur[2] && !cur[1]),
				!(cur[2] && !cur[1]), cur > 3'h1, cur < 3'h2, cur == 3'h7,
				!(cur[2] && !cur[1]), 1'b0}));
			reg_rd(CPMD_REG_MODE, rv);
			check("mode", 16'(rv[5:0]), 16'({cur, mode_of[cur]}));
			@(posedge clk_i);
			oc <= 1'b1;
			wait_n(5);
			check("fault", 16'(ftn), 16'(cur == 3'h0 || (cur[2] && cur != 3'h7)));
			@(posedge clk_i);
			oc <= 1'b0;
			above <= 1'b1;
			wait_n(30);
			check("status on", 16'(stn), 16'(!(cur == 3'h1 || cur == 3'h7)));
			@(posedge clk_i);
			above <= 1'b0;
			below <= 1'b1;
			wait_n(40);
			check("status off", 16'(stn), 16'h0001);
			@(posedge clk_i);
			below <= 1'b0;
			prev = cur;
		end
		// Code-change event raises the interrupt only when unmasked
		check("irq masked", 16'(irq), 16'h0000);
		reg_wr(CPMD_REG_IRQ_MASK, 8'h01);
		wait_n(3);
		check("irq", 16'(irq), 16'h0001);
		reg_wr(CPMD_REG_IRQ_STATUS, 8'h01);
		wait_n(3);
		check("irq clear", 16'(irq), 16'h0000);
		reg_wr(4'hF, 8'hFF);
		reg_rd(4'hF, rv);
		check("unmapped", 16'(rv), 16'h0000);
		// Software force-off drops switch, data and auto detection
		reg_wr(CPMD_REG_CTRL, 8'h01);
		wait_n(2);
		check("forced off", 16'({pwr, dsw, dauto}), 16'h0000);
		reg_rd(CPMD_REG_CTRL, rv);
		check("ctrl", 16'(rv), 16'h0001);
		// Enable pin low also drops the port, after its two sync flops
		reg_wr(CPMD_REG_CTRL, 8'h00);
		@(posedge clk_i);
		en <= 1'b0;
		wait_n(4);
		check("disabled", 16'({pwr, dsw, dauto}), 16'h0000);
		report_and_stop();
	end
	// Watchdog against a hang
	initial begin
		// About twice the 13,000 cycles the tests need
		#300_000;
		mismatches++;
		report_and_stop();
	end
endmodule
